// ==== common/sdf_pkg.sv ====
// Package of constants for the serial audio input deformatter
//
// Operation
// - Accept LJ, I2S, RJ; 16/18/20/24-bit words
// - LJ/RJ: frame clock high means left
// - I2S is code 0; frame clock low means left; unused code 3 decodes as LJ
// - Data sampled on bit clock rising edge
// - RJ: MSB follows slot so LSB ends it
// - I2S: MSB one bit clock after transition
// - LJ: MSB at first bit clock, no delay
package sdf_pkg;

    // ------------------------------------------------------------
    // Framing formats
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SDF_FMT_I2S,
        SDF_FMT_LJ,
        SDF_FMT_RJ
    } sdf_fmt_type;

    // ------------------------------------------------------------
    // Word width codes
    // ------------------------------------------------------------
    localparam logic [1:0] SDF_WL_16 = 2'h0; // 16-bit words
    localparam logic [1:0] SDF_WL_18 = 2'h1; // 18-bit words
    localparam logic [1:0] SDF_WL_20 = 2'h2; // 20-bit words
    localparam logic [1:0] SDF_WL_24 = 2'h3; // 24-bit words

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int SDF_MAX_BITS = 24;           // Widest sample word
    localparam int SDF_CNT_W = 6;               // Bit counter width, 64-bit-clock frames
    localparam int SDF_SLOT_BITS = 32;          // Bit clocks per channel slot
    localparam int SDF_FIFO_DEPTH = 4;          // Sample-pair buffer depth
    localparam logic [23:0] SDF_WORD_RST = 24'h000000; // Shift register reset

endpackage : sdf_pkg

// ==== src/sdf_deformatter.sv ====
// Serial audio input deformatter with sample-pair FIFO
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Sample-pair FIFO
// ----------------------------------------------------------------
module sdf_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];   // Storage array
    logic [AW-1:0] wr_q;               // Write index
    logic [AW-1:0] rd_q;               // Read index
    logic [AW:0] cnt_q;                // Fill level
    logic do_wr;
    logic do_rd;

    // Level is one bit wider than the index, so compare at that width
    assign in_ready = (cnt_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign do_wr = ce && in_valid && in_ready;
    assign do_rd = ce && out_valid && out_ready;

    // Storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            // Simultaneous push and pop leaves level unchanged
            if (do_wr && !do_rd) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : sdf_fifo

// ----------------------------------------------------------------
// Deformatter top
// ----------------------------------------------------------------
module sdf_deformatter #(
    parameter int DEPTH = sdf_pkg::SDF_FIFO_DEPTH
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Configuration
    input wire logic [1:0] fmt_sel,
    input wire logic [1:0] wlen_sel,
    // Serial pins
    input wire logic bit_clk,
    input wire logic frame_clk,
    input wire logic ser_data,
    // Sample pair to encoder
    output logic pair_valid,
    input wire logic pair_ready,
    output logic [sdf_pkg::SDF_MAX_BITS-1:0] left_word,
    output logic [sdf_pkg::SDF_MAX_BITS-1:0] right_word,
    // Status
    output logic overrun
);
    localparam int W = sdf_pkg::SDF_MAX_BITS;

    // Pin synchronisers: stage one feeds stage two only
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic bclk_prev_q;                 // Previous synced bit clock
    logic lr_prev_q;                   // Frame clock at previous rise
    logic [sdf_pkg::SDF_CNT_W-1:0] pos_q; // Bit clocks since frame edge
    logic [W-1:0] shift_q;             // Current channel word
    logic [W-1:0] left_q;              // Captured left word
    logic push_q;                      // Pair ready to push
    logic rseen_q;                     // A right slot began since reset
    logic [W-1:0] pl_q;
    logic [W-1:0] pr_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [2*W-1:0] fifo_out;
    logic rise;
    logic lr_now;
    logic sd_now;
    logic lr_edge;
    logic is_left;
    logic [5:0] wbits;
    logic [5:0] start;
    logic [5:0] idx;
    logic take;

    // Two-flop capture of the external pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            bclk_prev_q <= 1'b0;
        end else if (ce) begin
            s1_q <= {bit_clk, frame_clk, ser_data};
            s2_q <= s1_q;
            bclk_prev_q <= s2_q[2];
        end
    end

    assign rise = s2_q[2] && !bclk_prev_q;
    assign lr_now = s2_q[1];
    assign sd_now = s2_q[0];
    assign lr_edge = (lr_now != lr_prev_q);

    // Channel polarity by format
    always_comb begin
        if (fmt_sel == 2'(sdf_pkg::SDF_FMT_I2S)) begin
            is_left = !lr_now;
        end else begin
            is_left = lr_now;
        end
    end

    // Word width decode
    always_comb begin
        case (wlen_sel)
            sdf_pkg::SDF_WL_16: wbits = 6'd16;
            sdf_pkg::SDF_WL_18: wbits = 6'd18;
            sdf_pkg::SDF_WL_20: wbits = 6'd20;
            default: wbits = 6'd24;
        endcase
    end

    // First bit position of the MSB within the slot
    always_comb begin
        case (fmt_sel)
            2'(sdf_pkg::SDF_FMT_I2S): start = 6'd1;
            2'(sdf_pkg::SDF_FMT_RJ): start = 6'(sdf_pkg::SDF_SLOT_BITS) - wbits;
            default: start = 6'd0;
        endcase
    end

    // Position of this bit: zero on the rise that sees a frame edge
    assign idx = lr_edge ? 6'd0 : pos_q + 1'b1;
    // Only bits inside the word window are kept
    assign take = (idx >= start) && (idx < start + wbits);

    // Bit counter and shift register, advanced on bit clock rises
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_q <= '0;
            lr_prev_q <= 1'b0;
            shift_q <= sdf_pkg::SDF_WORD_RST;
            left_q <= sdf_pkg::SDF_WORD_RST;
        end else if (ce && rise) begin
            lr_prev_q <= lr_now;
            pos_q <= (idx == 6'h3f) ? idx : idx;
            if (lr_edge) begin
                // Slot ended: a finished left word is filed in left_q
                if (!is_left) begin
                    left_q <= shift_q;
                end
                shift_q <= take ? W'(sd_now) : '0;
            end else if (take) begin
                shift_q <= {shift_q[W-2:0], sd_now};
            end
        end
    end

    // Pair hand-off when the right word closes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            push_q <= 1'b0;
            rseen_q <= 1'b0;
            pl_q <= '0;
            pr_q <= '0;
            overrun <= 1'b0;
        end else if (ce) begin
            push_q <= 1'b0;
            if (rise && lr_edge && !is_left) begin
                // A right word will close from here on
                rseen_q <= 1'b1;
            end
            // No pair until a right word was captured after reset
            if (rise && lr_edge && is_left && rseen_q) begin
                // New left slot starts: right word just finished
                push_q <= 1'b1;
                pl_q <= left_q;
                pr_q <= shift_q;
                // Buffer full drops the pair and flags it
                if (!fifo_in_ready) begin
                    overrun <= 1'b1;
                end
            end
        end
    end

    sdf_fifo #(
        .WIDTH(2 * W),
        .DEPTH(DEPTH)
    ) fifo_i (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(push_q),
        .in_ready(fifo_in_ready),
        .in_data({pl_q, pr_q}),
        .out_valid(fifo_out_valid),
        .out_ready(pair_ready && !pair_valid),
        .out_data(fifo_out)
    );

    // Registered output stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pair_valid <= 1'b0;
            left_word <= '0;
            right_word <= '0;
        end else if (ce) begin
            if (pair_valid && pair_ready) begin
                pair_valid <= 1'b0;
            end else if (!pair_valid && fifo_out_valid && pair_ready) begin
                pair_valid <= 1'b1;
                left_word <= fifo_out[2*W-1:W];
                right_word <= fifo_out[W-1:0];
            end
        end
    end
endmodule : sdf_deformatter

// ==== verification/sdf_deformatter_assertions.sv ====
// Checker for the deformatter's port behaviour
`timescale 1ns/1ns
module sdf_chk (
    // Watched ports
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] fmt_sel,
    input wire logic [1:0] wlen_sel,
    input wire logic frame_clk,
    input wire logic pair_valid,
    input wire logic pair_ready,
    input wire logic [23:0] left_word,
    input wire logic [23:0] right_word,
    input wire logic overrun
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic moved_q; // Config moved since reset, width checks then void
    logic got_q; // First pair seen, so frame timing has settled
    always_ff @(posedge clk) begin
        if (!rst_n) moved_q <= 1'b0;
        else if ($changed(wlen_sel) || $changed(fmt_sel)) moved_q <= 1'b1;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) got_q <= 1'b0;
        else if (pair_valid) got_q <= 1'b1;
    end
    property p_clear; $rose(rst_n) |-> !pair_valid && !overrun; endproperty
    property p_hold; pair_valid && !pair_ready |=> pair_valid && $stable(left_word)
        && $stable(right_word); endproperty
    property p_drop; pair_valid && pair_ready |=> !pair_valid; endproperty
    property p_sticky; overrun |=> overrun; endproperty
    property p_ovr; $rose(overrun) |-> frame_clk == (fmt_sel != 2'h0); endproperty
    property p_w16; !moved_q && pair_valid && wlen_sel == 2'h0
        |-> left_word[23:16] == 8'h00 && right_word[23:16] == 8'h00; endproperty
    property p_w20; !moved_q && pair_valid && wlen_sel == 2'h2
        |-> left_word[23:20] == 4'h0 && right_word[23:20] == 4'h0; endproperty
    property p_i2s; !moved_q && got_q && fmt_sel == 2'h0 && $fell(frame_clk)
        |-> ##[1:40] pair_valid; endproperty
    property p_lj; !moved_q && got_q && fmt_sel != 2'h0 && $rose(frame_clk)
        |-> ##[1:40] pair_valid; endproperty
    a_clear: assert property (p_clear) else $error("outputs set after reset");
    a_hold: assert property (p_hold) else $error("pair not held");
    a_drop: assert property (p_drop) else $error("pair offered twice");
    a_sticky: assert property (p_sticky) else $error("overrun cleared");
    a_ovr: assert property (p_ovr) else $error("overrun outside a left slot start");
    a_w16: assert property (p_w16) else $error("bits above 16");
    a_w20: assert property (p_w20) else $error("bits above 20");
    a_i2s: assert property (p_i2s) else $error("no pair at low frame");
    a_lj: assert property (p_lj) else $error("no pair at high frame");
    c_take: cover property (pair_valid && pair_ready);
    c_stall: cover property (pair_valid && !pair_ready);
    c_over: cover property ($rose(overrun));
endmodule : sdf_chk

// ==== verification/sdf_src_model.sv ====
// Serial audio source: bit clock, frame clock and data
`timescale 1ns/1ns
module sdf_src_model (
    // Serial pins
    output logic bit_clk,
    output logic frame_clk,
    output logic ser_data
);
    initial begin
        bit_clk = 1'b0;
        frame_clk = 1'b0;
        ser_data = 1'b0;
    end
    // One 64-bit frame; bit clock stands low between frames
    task automatic send(input logic [1:0] fmt, input int w, input logic [23:0] l, r,
        input logic [31:0] junk);
        int s;
        logic lft;
        logic [23:0] wd;
        s = fmt == 2'h0 ? 1 : (fmt == 2'h2 ? 32 - w : 0);
        lft = fmt != 2'h0;
        #7;
        for (int p = 0; p < 64; p++) begin
            frame_clk = p < 32 ? lft : !lft;
            wd = p < 32 ? l : r;
            junk = {junk[30:0], junk[31] ^ junk[21]};
            // Outside the word the line carries junk, which must be ignored
            if (p % 32 >= s && p % 32 < s + w) ser_data = wd[w - 1 - (p % 32 - s)];
            else ser_data = junk[0];
            #80 bit_clk = 1'b1;
            #80 bit_clk = 1'b0;
        end
        ser_data = !ser_data;
    endtask : send
endmodule : sdf_src_model

// ==== verification/tb_spdif_tx_serial_input_deformatter.sv ====
// Self-checking bench for the serial audio input deformatter
`timescale 1ns/1ns
module tb_spdif_tx_serial_input_deformatter;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pair_ready = 1'b0;
    logic stall = 1'b0;
    logic skip_ok = 1'b1;
    logic [1:0] fmt_sel = 2'h0;
    logic [1:0] wlen_sel = 2'h0;
    logic bit_clk, frame_clk, ser_data, pair_valid, overrun;
    logic [23:0] left_word, right_word;
    logic [31:0] rnd_q = 32'hd6b3;
    logic [47:0] exp_q[$];
    logic [47:0] exp_w; // Expected pair being compared
    int bad_count = 0;
    int tests_run = 0;
    always #10 clk = ~clk;
    sdf_deformatter #(.DEPTH(4)) u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .fmt_sel(fmt_sel), .wlen_sel(wlen_sel), .bit_clk(bit_clk), .frame_clk(frame_clk),
        .ser_data(ser_data), .pair_valid(pair_valid), .pair_ready(pair_ready),
        .left_word(left_word), .right_word(right_word), .overrun(overrun));
    sdf_src_model u_src (.bit_clk(bit_clk), .frame_clk(frame_clk), .ser_data(ser_data));
    function automatic logic [31:0] xorshift(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xorshift
    task automatic check(input logic [47:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Random stalls on the encoder side
    always @(negedge clk) begin
        rnd_q <= xorshift(rnd_q);
        pair_ready <= !stall && rnd_q[1:0] != 2'h0;
    end
    // Each accepted pair against the model queue
    always @(posedge clk) begin
        if (rst_n && pair_valid === 1'b1 && pair_ready === 1'b1) begin
            exp_w = exp_q.size() ? exp_q.pop_front() : 48'hx;
            // I2S first left word has no frame edge before it, so may be partial
            if (skip_ok && fmt_sel == 2'h0) begin
                check({24'h0, right_word}, {24'h0, exp_w[23:0]});
            end else begin
                check({left_word, right_word}, exp_w);
            end
            skip_ok = 1'b0;
        end
    end
    task automatic run(input logic [1:0] f, wl, input int n, input logic st);
        int w;
        logic [23:0] l, r;
        w = wl == 2'h3 ? 24 : 16 + 2 * wl;
        @(negedge clk);
        fmt_sel = f;
        wlen_sel = wl;
        rst_n = 1'b0;
        skip_ok = 1'b1;
        stall = st;
        exp_q.delete();
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i <= n; i++) begin
            l = rnd_q[23:0] & ((24'h1 << w) - 1);
            r = {rnd_q[7:0], rnd_q[31:16]} & ((24'h1 << w) - 1);
            if (i < n) exp_q.push_back({l, r});
            u_src.send(f, w, l, r, rnd_q);
        end
        check({47'h0, overrun}, {47'h0, st});
        stall = 1'b0;
        repeat (80) @(negedge clk);
        if (!st) check({16'h0, exp_q.size()}, 48'h0);
        $display("test fmt=%0d wlen=%0d done", f, wl);
    endtask : run
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    initial begin
        for (int f = 0; f < 3; f++)
            for (int wl = 0; wl < 4; wl++) run(f[1:0], wl[1:0], 2, 1'b0);
        run(2'h1, 2'h2, 8, 1'b1);
        end_sim();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #1000000;
        bad_count++;
        end_sim();
    end
endmodule : tb_spdif_tx_serial_input_deformatter
bind sdf_deformatter sdf_chk u_chk (.clk(clk), .rst_n(rst_n), .fmt_sel(fmt_sel),
    .wlen_sel(wlen_sel), .frame_clk(frame_clk), .pair_valid(pair_valid),
    .pair_ready(pair_ready), .left_word(left_word), .right_word(right_word),
    .overrun(overrun));
